// ---- hw/mqf_defs.svh ----
/*
 * constants of the multi-queue flag status logic: queue count, data field
 * positions, default offsets, width select codes, host register offsets.
 * assumes inclusion by bare name from the interface, device and host files of the block.
 */
`ifndef MQF_DEFS_SVH
`define MQF_DEFS_SVH

// queue and data layout
`define MQF_NUM_QUEUES 8
`define MQF_MAX_DEVICES 8
`define MQF_MAX_TOTAL_QUEUES 64
`define MQF_DATA_W 36
`define MQF_SOP_BIT 34
`define MQF_EOP_BIT 35
`define MQF_QSEL_W 3
`define MQF_DSEL_W 3
`define MQF_ADDR_W 6

// default offsets chosen by the offset select strap
`define MQF_OFFSET_LOW 9'h008
`define MQF_OFFSET_HIGH 9'h080

// width select code for a full 36-bit port
`define MQF_WIDTH_36 2'h0

// host register word indices, byte address bits 4:2
`define MQF_REG_CTRL 4'h0
`define MQF_REG_WR_ADDR 4'h1
`define MQF_REG_RD_ADDR 4'h2
`define MQF_REG_WR_DATA 4'h3
`define MQF_REG_RD_CMD 4'h4
`define MQF_REG_RD_DATA 4'h5
`define MQF_REG_STATUS 4'h6
`define MQF_REG_STROBE 4'h7

// control register field positions
`define MQF_CTRL_MODE 0
`define MQF_CTRL_OFFSET 1
`define MQF_CTRL_PKT 2
`define MQF_CTRL_IW_LO 3
`define MQF_CTRL_OW_LO 5
`define MQF_CTRL_MATCH 7
`define MQF_CTRL_QCNT_LO 8
`define MQF_CTRL_RESET 32'h0000_0800

`endif

// ---- hw/mqf_pkg.sv ----
/*
 * types of the multi-queue flag status link; only the device end refers to the package.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package mqf_pkg;
   // flag bus operating mode, caught at master reset
   typedef enum logic {
      MQF_DIRECT = 1'b0,
      MQF_POLLED = 1'b1
   } mqf_mode_type;

   // port width select
   typedef enum logic [1:0] {
      MQF_W36 = 2'b00,
      MQF_W18 = 2'b01,
      MQF_W9 = 2'b10
   } mqf_width_type;
endpackage

// ---- hw/mqf_if.sv ----
/*
 * link between the host controller and one multi-queue device.
 * assumes one clock mclk for both ports; shared flag busses are resolved
 * here with a pull-up, so an undriven bus reads all ones.
 */
`timescale 1ns/100ps
`include "mqf_defs.svh"

interface mqf_if;
   // write port
   logic wr_en_n;
   logic [`MQF_ADDR_W-1:0] wr_addr;
   logic [`MQF_DATA_W-1:0] din;
   logic full_bus_strobe;
   // read port
   logic rd_en_n;
   logic [`MQF_ADDR_W-1:0] rd_addr;
   logic [`MQF_DATA_W-1:0] dout;
   logic output_valid_flag_n;
   logic packet_ready_flag_n;
   logic empty_bus_strobe;
   logic empty_bus_sync_pulse;
   // flag busses, device side drive and resolved level
   logic [7:0] af_bus_out;
   logic af_bus_oe;
   logic [7:0] ae_bus_out;
   logic ae_bus_oe;
   logic [7:0] almost_full_status_bus;
   logic [7:0] almost_empty_status_bus;
   // configuration straps
   logic flag_bus_mode_select;
   logic default_offset_select;
   logic packet_mode_select;
   logic width_match_select;
   logic [1:0] input_width_select;
   logic [1:0] output_width_select;
   logic [3:0] queue_count;

   // pull-up resolution of the shared busses
   assign almost_full_status_bus = af_bus_oe ? af_bus_out : 8'hFF;
   assign almost_empty_status_bus = ae_bus_oe ? ae_bus_out : 8'hFF;

   modport device (
      input wr_en_n, wr_addr, din, full_bus_strobe, rd_en_n, rd_addr, empty_bus_strobe,
      input flag_bus_mode_select, default_offset_select, packet_mode_select,
      input width_match_select, input_width_select, output_width_select, queue_count,
      output dout, output_valid_flag_n, packet_ready_flag_n, empty_bus_sync_pulse,
      output af_bus_out, af_bus_oe, ae_bus_out, ae_bus_oe
   );
   modport host (
      output wr_en_n, wr_addr, din, full_bus_strobe, rd_en_n, rd_addr, empty_bus_strobe,
      output flag_bus_mode_select, default_offset_select, packet_mode_select,
      output width_match_select, input_width_select, output_width_select, queue_count,
      input dout, output_valid_flag_n, packet_ready_flag_n, empty_bus_sync_pulse,
      input almost_full_status_bus, almost_empty_status_bus
   );
endinterface

// ---- hw/mqf_device.sv ----
/*
 * multi-queue device end: queue storage, per-queue almost full, almost
 * empty and packet ready state, and the two shared 8-bit flag busses.
 * assumes the host runs on mclk, so link inputs need no synchroniser;
 * reset is the master reset and catches the configuration straps.
 */
// Overview of operation
// - separate 8-bit almost-full and almost-empty busses
// - unconfigured queue positions carry no status
// - busses may be private or shared across devices
// - polled bus steps to next device each edge
// - full bus on write edges, empty on read
// - direct mode: host picks bus owner by address
// - packet mode only with both ports 36 bits
// - host marks first word bit 34, last 35
// - packets of any length up to memory
// - after start marker, watch for end marker
// - packet ready with output valid: packet waiting
// - packet mode: empty bus shows packet ready
// - up to 8 devices wired in parallel
// - queue expansion reaches at most 64 queues
// - data captured on write edge when enabled
// - host holds unused data inputs low
// - width match strap set before reset, stable
// - offset strap at reset: 8 or 128
// - mode strap at reset: high polled, low direct
// - polled: sync output high while own empty flags shown
// - direct: addressed device takes bus on strobe
`timescale 1ns/100ps
`include "mqf_defs.svh"

module mqf_device #(
   parameter int DEPTH = 256,
   parameter int DEV_ID = 0,
   parameter int NUM_DEVICES = 1
) (
   // clock and master reset
   input wire logic mclk,
   input wire logic reset,
   // link to the host
   mqf_if.device link
);
   localparam int NQ = `MQF_NUM_QUEUES;
   localparam int PW = $clog2(DEPTH);
   localparam int CW = PW + 1;
   localparam int QW = `MQF_QSEL_W;
   localparam int DW = `MQF_DSEL_W;

   // refuse sizes the logic cannot serve
   if (DEPTH < 256 || (DEPTH & (DEPTH - 1)) != 0)
      $error("depth must be a power of two of at least 256");
   if (NUM_DEVICES < 1 || NUM_DEVICES * NQ > `MQF_MAX_TOTAL_QUEUES || DEV_ID >= NUM_DEVICES)
      $error("device count or identity out of range");

   ////////////////////////////////////////////////////////////////////////////
   // configuration caught at master reset

   logic mode_q;
   logic [CW-1:0] offset_q;
   logic pkt_mode_q;
   logic [3:0] qcount_q;

   // straps are sampled on every clock edge while reset is high and frozen after release
   always_ff @(posedge mclk) begin
      if (reset) begin
         mode_q <= link.flag_bus_mode_select;
         offset_q <= CW'(link.default_offset_select ? `MQF_OFFSET_HIGH : `MQF_OFFSET_LOW);
         pkt_mode_q <= link.packet_mode_select &&
                       link.input_width_select == `MQF_WIDTH_36 &&
                       link.output_width_select == `MQF_WIDTH_36;
         qcount_q <= (link.queue_count == 4'h0 || link.queue_count > 4'h8) ? 4'h8
                     : link.queue_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // port decode

   logic [QW-1:0] wq;
   logic [QW-1:0] rq;
   logic wr_go;
   logic rd_go;
   logic [NQ-1:0] active;
   logic [CW-1:0] cnt_q [NQ];
   logic [PW-1:0] wp_q [NQ];
   logic [PW-1:0] rp_q [NQ];
   logic [CW-1:0] pkts_q [NQ];
   logic [NQ-1:0] in_pkt_q;
   logic [NQ-1:0] af_vec;
   logic [NQ-1:0] ae_vec;
   logic [NQ-1:0] pr_vec;
   logic [`MQF_DATA_W-1:0] mem [NQ*DEPTH];
   logic [`MQF_DATA_W-1:0] rd_word;

   assign wq = link.wr_addr[QW-1:0];
   assign rq = link.rd_addr[QW-1:0];
   assign rd_word = mem[{rq, rp_q[rq]}];
   // write only when enabled, addressed, active and not full
   assign wr_go = !link.wr_en_n && link.wr_addr[QW+DW-1:QW] == DW'(DEV_ID) &&
                  active[wq] && cnt_q[wq] != CW'(DEPTH);
   assign rd_go = !link.rd_en_n && link.rd_addr[QW+DW-1:QW] == DW'(DEV_ID) &&
                  active[rq] && cnt_q[rq] != '0;

   // packets limited only by queue storage
   always_ff @(posedge mclk) begin
      if (wr_go) begin
         mem[{wq, wp_q[wq]}] <= link.din;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-queue pointers, levels and packet tracking

   for (genvar q = 0; q < NQ; q++) begin : g_queue
      logic wr_here;
      logic rd_here;
      logic eop_in;
      logic eop_out;

      assign wr_here = wr_go && wq == QW'(q);
      assign rd_here = rd_go && rq == QW'(q);
      // end marker after a start marker closes a packet
      assign eop_in = wr_here && link.din[`MQF_EOP_BIT] &&
                      (in_pkt_q[q] || link.din[`MQF_SOP_BIT]);
      assign eop_out = rd_here && rd_word[`MQF_EOP_BIT];
      // only the first configured queues are live
      assign active[q] = 4'(q) < qcount_q;

      // level and pointers
      always_ff @(posedge mclk) begin
         if (reset) begin
            cnt_q[q] <= '0;
            wp_q[q] <= '0;
            rp_q[q] <= '0;
         end else begin
            cnt_q[q] <= cnt_q[q] + CW'(wr_here) - CW'(rd_here);
            if (wr_here)
               wp_q[q] <= wp_q[q] + 1'b1;
            if (rd_here)
               rp_q[q] <= rp_q[q] + 1'b1;
         end
      end

      // start marker opens watch for end marker
      always_ff @(posedge mclk) begin
         if (reset || !pkt_mode_q) begin
            in_pkt_q[q] <= 1'b0;
            pkts_q[q] <= '0;
         end else begin
            if (wr_here && link.din[`MQF_EOP_BIT])
               in_pkt_q[q] <= 1'b0;
            else if (wr_here && link.din[`MQF_SOP_BIT])
               in_pkt_q[q] <= 1'b1;
            pkts_q[q] <= pkts_q[q] + CW'(eop_in) - CW'(eop_out && pkts_q[q] != '0);
         end
      end

      // conditions, turned active low at the bus
      assign af_vec[q] = active[q] && cnt_q[q] >= CW'(DEPTH) - offset_q;
      assign ae_vec[q] = active[q] && cnt_q[q] <= offset_q;
      assign pr_vec[q] = active[q] && pkts_q[q] != '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port data, output valid and packet ready

   // packet ready for the selected queue beside output valid
   always_ff @(posedge mclk) begin
      if (reset) begin
         link.dout <= '0;
         link.output_valid_flag_n <= 1'b1;
         link.packet_ready_flag_n <= 1'b1;
      end else begin
         if (rd_go)
            link.dout <= rd_word;
         link.output_valid_flag_n <= !rd_go;
         link.packet_ready_flag_n <= !(pkt_mode_q && pr_vec[rq]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flag bus ownership

   logic [DW-1:0] af_slot_q;
   logic [DW-1:0] ae_slot_q;
   logic [DW-1:0] af_slot_d;
   logic [DW-1:0] ae_slot_d;
   logic af_sel_q;
   logic ae_sel_q;

   // slots step through devices in order
   assign af_slot_d = (af_slot_q == DW'(NUM_DEVICES - 1)) ? '0 : af_slot_q + 1'b1;
   assign ae_slot_d = (ae_slot_q == DW'(NUM_DEVICES - 1)) ? '0 : ae_slot_q + 1'b1;

   // both ports run on mclk, each bus its own slot
   always_ff @(posedge mclk) begin
      if (reset) begin
         af_slot_q <= DW'(NUM_DEVICES - 1);
         ae_slot_q <= DW'(NUM_DEVICES - 1);
      end else begin
         af_slot_q <= af_slot_d;
         ae_slot_q <= ae_slot_d;
      end
   end

   // write address picks full bus, read address empty bus
   // taken only while the strobe is high
   always_ff @(posedge mclk) begin
      if (reset) begin
         af_sel_q <= 1'b0;
         ae_sel_q <= 1'b0;
      end else begin
         if (link.full_bus_strobe)
            af_sel_q <= link.wr_addr[QW+DW-1:QW] == DW'(DEV_ID);
         if (link.empty_bus_strobe)
            ae_sel_q <= link.rd_addr[QW+DW-1:QW] == DW'(DEV_ID);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flag bus drivers

   // two separate busses, one bit per queue
   // drive only when owning a shared bus
   always_ff @(posedge mclk) begin
      if (reset) begin
         link.af_bus_out <= 8'hFF;
         link.ae_bus_out <= 8'hFF;
         link.af_bus_oe <= 1'b0;
         link.ae_bus_oe <= 1'b0;
         link.empty_bus_sync_pulse <= 1'b0;
      end else begin
         link.af_bus_out <= ~af_vec;
         link.ae_bus_out <= pkt_mode_q ? ~pr_vec : ~ae_vec;
         if (mode_q == mqf_pkg::MQF_POLLED) begin
            link.af_bus_oe <= af_slot_d == DW'(DEV_ID);
            link.ae_bus_oe <= ae_slot_d == DW'(DEV_ID);
            link.empty_bus_sync_pulse <= ae_slot_d == DW'(DEV_ID);
         end else begin
            link.af_bus_oe <= af_sel_q || (link.full_bus_strobe &&
                              link.wr_addr[QW+DW-1:QW] == DW'(DEV_ID));
            link.ae_bus_oe <= ae_sel_q || (link.empty_bus_strobe &&
                              link.rd_addr[QW+DW-1:QW] == DW'(DEV_ID));
            link.empty_bus_sync_pulse <= 1'b0;
         end
         if (mode_q == mqf_pkg::MQF_DIRECT && link.full_bus_strobe &&
             link.wr_addr[QW+DW-1:QW] != DW'(DEV_ID))
            link.af_bus_oe <= 1'b0;
         if (mode_q == mqf_pkg::MQF_DIRECT && link.empty_bus_strobe &&
             link.rd_addr[QW+DW-1:QW] != DW'(DEV_ID))
            link.ae_bus_oe <= 1'b0;
      end
   end
endmodule

// ---- hw/mqf_host.sv ----
/*
 * host controller end: an Avalon-MM slave whose registers drive the
 * device's write and read ports, strobes and straps, and report its flags.
 * assumes software on mclk; straps take effect at the next reset.
 */
`timescale 1ns/100ps
`include "mqf_defs.svh"

module mqf_host (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Avalon-MM slave
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // link to the device
   mqf_if.host link
);
   logic [31:0] ctrl_q;
   logic [31:0] rd_data_q;
   logic [3:0] ov_pr_q;
   logic [3:0] idx;
   logic take_wr;

   assign idx = {1'b0, address[4:2]};
   assign take_wr = write && !waitrequest;

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake: one wait cycle, answer at the second edge

   always_ff @(posedge mclk) begin
      if (reset)
         waitrequest <= 1'b1;
      else
         waitrequest <= !((read || write) && waitrequest);
   end

   // read data loaded with the answer
   always_ff @(posedge mclk) begin
      if (reset) begin
         readdata <= '0;
      end else if (read && waitrequest) begin
         case (idx)
            `MQF_REG_CTRL: readdata <= ctrl_q;
            `MQF_REG_WR_ADDR: readdata <= 32'(link.wr_addr);
            `MQF_REG_RD_ADDR: readdata <= 32'(link.rd_addr);
            `MQF_REG_RD_DATA: readdata <= rd_data_q;
            `MQF_REG_STATUS: readdata <= {12'h000, ov_pr_q,
                                          link.almost_empty_status_bus,
                                          link.almost_full_status_bus};
            default: readdata <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control and straps

   always_ff @(posedge mclk) begin
      if (reset)
         ctrl_q <= ctrl_q;
      else if (take_wr && idx == `MQF_REG_CTRL)
         ctrl_q <= writedata;
   end

   // straps stable outside reset
   // straps reload from the control register only while reset is high
   always_ff @(posedge mclk) begin
      if (reset) begin
         link.flag_bus_mode_select <= ctrl_q[`MQF_CTRL_MODE];
         link.default_offset_select <= ctrl_q[`MQF_CTRL_OFFSET];
         link.packet_mode_select <= ctrl_q[`MQF_CTRL_PKT];
         link.input_width_select <= ctrl_q[`MQF_CTRL_IW_LO +: 2];
         link.output_width_select <= ctrl_q[`MQF_CTRL_OW_LO +: 2];
         link.width_match_select <= ctrl_q[`MQF_CTRL_MATCH];
         link.queue_count <= ctrl_q[`MQF_CTRL_QCNT_LO +: 4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // port commands

   // markers travel in bits 35 and 34 of the word
   always_ff @(posedge mclk) begin
      if (reset) begin
         link.wr_en_n <= 1'b1;
         link.rd_en_n <= 1'b1;
         link.wr_addr <= '0;
         link.rd_addr <= '0;
         link.din <= '0;
         link.full_bus_strobe <= 1'b0;
         link.empty_bus_strobe <= 1'b0;
      end else begin
         link.wr_en_n <= 1'b1;
         link.rd_en_n <= 1'b1;
         link.full_bus_strobe <= 1'b0;
         link.empty_bus_strobe <= 1'b0;
         if (take_wr) begin
            case (idx)
               `MQF_REG_WR_ADDR: link.wr_addr <= writedata[5:0];
               `MQF_REG_RD_ADDR: link.rd_addr <= writedata[5:0];
               `MQF_REG_WR_DATA: begin
                  link.din <= {writedata[31:30], 4'h0, writedata[29:0]};
                  link.wr_en_n <= 1'b0;
               end
               `MQF_REG_RD_CMD: link.rd_en_n <= 1'b0;
               `MQF_REG_STROBE: begin
                  link.full_bus_strobe <= writedata[0];
                  link.empty_bus_strobe <= writedata[1];
               end
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read side capture

   // packet ready and output valid kept for software
   always_ff @(posedge mclk) begin
      if (reset) begin
         rd_data_q <= '0;
         ov_pr_q <= '0;
      end else begin
         if (!link.output_valid_flag_n)
            rd_data_q <= {link.dout[35:34], link.dout[29:0]};
         ov_pr_q <= {1'b0, link.empty_bus_sync_pulse,
                     !link.packet_ready_flag_n, !link.output_valid_flag_n};
      end
   end
endmodule

// ---- tb/mqf_assertions.sv ----
/* checker of the host-device flag link, fed with the link signals.
   assumes one clock mclk and a synchronous active-high reset. */
`timescale 1ns/100ps
`include "mqf_defs.svh"

module mqf_assertions #(
   parameter int DEV_ID = 0,
   parameter int NUM_DEVICES = 1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // port requests
   input wire logic [`MQF_ADDR_W-1:0] wr_addr,
   input wire logic [`MQF_ADDR_W-1:0] rd_addr,
   input wire logic full_bus_strobe,
   input wire logic empty_bus_strobe,
   input wire logic rd_en_n,
   // device outputs
   input wire logic output_valid_flag_n,
   input wire logic packet_ready_flag_n,
   input wire logic empty_bus_sync_pulse,
   input wire logic [7:0] ae_bus_out,
   input wire logic ae_bus_oe,
   input wire logic af_bus_oe,
   // straps
   input wire logic flag_bus_mode_select,
   input wire logic packet_mode_select,
   input wire logic [1:0] input_width_select,
   input wire logic [1:0] output_width_select,
   input wire logic [3:0] queue_count
);
   logic polled_q;
   logic pkt_q;
   logic [7:0] idle_q;

   // straps as the device catches them at master reset
   always_ff @(posedge mclk) begin
      if (reset) begin
         polled_q <= flag_bus_mode_select;
         pkt_q <= packet_mode_select && input_width_select == 2'h0
            && output_width_select == 2'h0;
         idle_q <= (queue_count == 4'h0 || queue_count > 4'h8) ? 8'h00 : 8'hFF << queue_count;
      end
   end

   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   // direct-mode selection of the empty bus
   sequence s_own_empty;
      !polled_q && empty_bus_strobe && rd_addr[5:3] == DEV_ID[2:0];
   endsequence
   sequence s_other_empty;
      !polled_q && empty_bus_strobe && rd_addr[5:3] != DEV_ID[2:0];
   endsequence

   a_reset_quiet: assert property (disable iff (1'b0) reset |=> !ae_bus_oe && !af_bus_oe
      && !empty_bus_sync_pulse && output_valid_flag_n)
      else $error("flag busses driven after reset");
   a_empty_take: assert property (s_own_empty |=> ae_bus_oe)
      else $error("addressed device did not take empty bus");
   a_empty_drop: assert property (s_other_empty |=> !ae_bus_oe)
      else $error("empty bus kept after other device chosen");
   a_full_take: assert property (!polled_q && full_bus_strobe
      && wr_addr[5:3] == DEV_ID[2:0] |=> af_bus_oe)
      else $error("addressed device did not take full bus");
   a_direct_hold: assert property (!polled_q && !empty_bus_strobe |=> $stable(ae_bus_oe))
      else $error("empty bus owner changed without strobe");
   a_polled_own: assert property (NUM_DEVICES == 1 && polled_q && !$past(reset)
      |-> ae_bus_oe && af_bus_oe && empty_bus_sync_pulse)
      else $error("single polled device not on both busses");
   a_sync_direct: assert property (!polled_q |-> !empty_bus_sync_pulse)
      else $error("sync pulse in direct mode");
   a_idle_bits: assert property (ae_bus_oe |-> (ae_bus_out & idle_q) == idle_q)
      else $error("unconfigured queue shows status");
   a_pr_packet: assert property (!packet_ready_flag_n |-> pkt_q)
      else $error("packet ready outside packet mode");
   a_ov_read: assert property (!output_valid_flag_n |-> !$past(rd_en_n))
      else $error("output valid without a read");
endmodule

// ---- tb/tb.sv ----
/* testbench: host and device joined by the link, driven over Avalon-MM.
   assumes the register map of the host end, one word per index. */
`timescale 1ns/100ps

module tb;
   logic mclk;
   logic reset;
   logic [4:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic waitrequest;
   int fails;
   int num_checks;
   integer seed = 32'h0000_25bf;
   logic [31:0] rdat;
   logic [31:0] exp_q[$];

   // the two ends, the link and its checker
   mqf_if link_if();
   mqf_host mqf_host_inst (.mclk(mclk), .reset(reset), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .link(link_if));
   mqf_device #(.DEPTH(256), .DEV_ID(0), .NUM_DEVICES(1)) mqf_device_inst (.mclk(mclk),
      .reset(reset), .link(link_if));
   mqf_assertions #(.DEV_ID(0), .NUM_DEVICES(1)) mqf_assertions_inst (.mclk(mclk),
      .reset(reset), .wr_addr(link_if.wr_addr), .rd_addr(link_if.rd_addr),
      .full_bus_strobe(link_if.full_bus_strobe), .empty_bus_strobe(link_if.empty_bus_strobe),
      .rd_en_n(link_if.rd_en_n), .output_valid_flag_n(link_if.output_valid_flag_n),
      .packet_ready_flag_n(link_if.packet_ready_flag_n),
      .empty_bus_sync_pulse(link_if.empty_bus_sync_pulse), .ae_bus_out(link_if.ae_bus_out),
      .ae_bus_oe(link_if.ae_bus_oe), .af_bus_oe(link_if.af_bus_oe),
      .flag_bus_mode_select(link_if.flag_bus_mode_select),
      .packet_mode_select(link_if.packet_mode_select),
      .input_width_select(link_if.input_width_select),
      .output_width_select(link_if.output_width_select), .queue_count(link_if.queue_count));

   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one Avalon transfer, held until waitrequest is seen low; only the watchdog ends a wait
   task automatic bus(input logic [2:0] idx, input logic wr, input logic [31:0] d);
      @(posedge mclk);
      address <= {idx, 2'b00};
      write <= wr;
      read <= !wr;
      writedata <= d;
      do begin
         @(posedge mclk);
      end while (waitrequest !== 1'b0);
      rdat = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask

   // straps then master reset
   task automatic setup(input logic [31:0] c);
      bus(3'd0, 1'b1, c);
      @(posedge mclk);
      reset <= 1'b1;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
   endtask

   // status read once flags have settled
   task automatic stat;
      repeat (4) @(posedge mclk);
      bus(3'd6, 1'b0, 32'h0000_0000);
   endtask

   // random words to one queue, markers in the top two bits
   task automatic push(input logic [2:0] q, input int n, input logic [1:0] mk);
      logic [31:0] d;
      bus(3'd1, 1'b1, 32'(q));
      for (int i = 0; i < n; i++) begin
         d = {mk, 30'($random(seed))};
         exp_q.push_back(d);
         bus(3'd3, 1'b1, d);
      end
   endtask

   function automatic logic [31:0] ctl(input logic mode, input logic off, input logic pkt,
         input logic [1:0] iw, input logic [3:0] qc);
      return {20'h0_0000, qc, 3'h0, iw, pkt, off, mode};
   endfunction

   // empty bus with every active queue empty
   function automatic logic [7:0] idle_bits(input int n);
      return (n == 0 || n > 8) ? 8'h00 : 8'hFF << n;
   endfunction

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      end_of_test;
   end

   ////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      reset = 1'b1;
      address = 5'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      fails = 0;
      num_checks = 0;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      for (int n = 0; n < 10; n++) begin
         setup(ctl(1'b1, 1'b0, 1'b0, 2'h0, 4'(n)));
         stat;
         chk(32'(rdat[15:8]), 32'(idle_bits(n)));
         chk(32'(rdat[18]), 32'h0000_0001);
         chk(32'(rdat[7:0]), 32'h0000_00ff);
      end
      $display("queue count test done");
      setup(ctl(1'b1, 1'b0, 1'b0, 2'h0, 4'h4));
      push(3'd1, 8, 2'b00);
      stat;
      chk(32'(rdat[15:8]), 32'h0000_00f0);
      push(3'd1, 1, 2'b00);
      stat;
      chk(32'(rdat[15:8]), 32'h0000_00f2);
      bus(3'd2, 1'b1, 32'h0000_0001);
      while (exp_q.size() > 0) begin
         bus(3'd4, 1'b1, 32'h0000_0000);
         repeat (2) @(posedge mclk);
         bus(3'd5, 1'b0, 32'h0000_0000);
         chk(rdat, exp_q.pop_front());
      end
      stat;
      chk(32'(rdat[15:8]), 32'h0000_00f0);
      $display("offset 8 test done");
      setup(ctl(1'b1, 1'b1, 1'b0, 2'h0, 4'h4));
      push(3'd0, 128, 2'b00);
      stat;
      chk(32'(rdat[15:8]), 32'h0000_00f0);
      push(3'd0, 1, 2'b00);
      stat;
      chk(32'(rdat[15:8]), 32'h0000_00f1);
      exp_q.delete();
      $display("offset 128 test done");
      setup(ctl(1'b0, 1'b0, 1'b0, 2'h0, 4'h4));
      stat;
      chk(32'(rdat[18:8]), 32'h0000_00ff);
      bus(3'd2, 1'b1, 32'h0000_0000);
      bus(3'd7, 1'b1, 32'h0000_0002);
      stat;
      chk(32'(rdat[15:8]), 32'h0000_00f0);
      bus(3'd2, 1'b1, 32'h0000_0008);
      bus(3'd7, 1'b1, 32'h0000_0002);
      stat;
      chk(32'(rdat[15:8]), 32'h0000_00ff);
      push(3'd0, 247, 2'b00);
      bus(3'd7, 1'b1, 32'h0000_0001);
      stat;
      chk(32'(rdat[7:0]), 32'h0000_00ff);
      push(3'd0, 1, 2'b00);
      stat;
      chk(32'(rdat[7:0]), 32'h0000_00fe);
      bus(3'd1, 1'b1, 32'h0000_0008);
      bus(3'd7, 1'b1, 32'h0000_0001);
      stat;
      chk(32'(rdat[7:0]), 32'h0000_00ff);
      exp_q.delete();
      $display("direct mode test done");
      setup(ctl(1'b1, 1'b0, 1'b1, 2'h0, 4'h4));
      push(3'd2, 1, 2'b01);
      push(3'd2, 2, 2'b00);
      bus(3'd2, 1'b1, 32'h0000_0002);
      stat;
      chk(32'(rdat[15:8]), 32'h0000_00ff);
      chk(32'(rdat[17]), 32'h0000_0000);
      push(3'd2, 1, 2'b10);
      push(3'd3, 1, 2'b10);
      stat;
      chk(32'(rdat[15:8]), 32'h0000_00fb);
      chk(32'(rdat[17]), 32'h0000_0001);
      setup(ctl(1'b1, 1'b0, 1'b1, 2'h1, 4'h4));
      stat;
      chk(32'(rdat[15:8]), 32'h0000_00f0);
      $display("packet test done");
      end_of_test;
   end
endmodule
